// file: design/swbe_core.sv
// sequencer, data memory and software registers of the subtract-with-borrow core
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "swbe_defines.svh"

module swbe_core
  import swbe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             instr_reject,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  swbe_state_t state_r;
  logic [7:0]  acc_r;
  logic [4:0]  status_r;
  logic [3:0]  bank_select_reg_r;
  logic        ext_en_r;
  logic [11:0] idx_base_r;
  logic [11:0] ptr_r;
  logic [7:0]  count_r;
  logic [11:0] addr_r;
  logic        dest_r;
  logic [7:0]  operand_r;
  logic [7:0]  res_r;
  logic [4:0]  flags_r;
  logic [7:0]  general_purpose_ram [0:4095];
  logic        take;
  logic        is_match;
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [7:0]  mem_wdata;

  swbe_alu_if alu_bus ();

  swbe_alu u_alu (
    .p (alu_bus.alu)
  );

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  function automatic logic [11:0] resolve_addr(input logic [7:0]  f,
                                               input logic        a,
                                               input logic [3:0]  bank,
                                               input logic        ext,
                                               input logic [11:0] base);
    logic [11:0] r;
    if (a) begin
      r = {bank, f};
    end else if (ext && (f <= `SWBE_IDX_LIMIT)) begin
      r = base + {4'h0, f};
    end else if (f <= `SWBE_IDX_LIMIT) begin
      r = {4'h0, f};
    end else begin
      r = {`SWBE_ACCESS_HI, f};
    end
    return r;
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign is_match    = (instr_word[`SWBE_OP_HI:`SWBE_OP_LO] == `SWBE_OPCODE);
  assign instr_ready = (state_r == SWBE_IDLE) || (state_r == SWBE_Q4);
  assign take        = instr_ready && instr_valid;

  // back-to-back words run one quarter after another with no idle gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SWBE_IDLE;
    end else begin
      case (state_r)
        SWBE_IDLE: state_r <= (take && is_match) ? SWBE_Q1 : SWBE_IDLE;
        SWBE_Q1:   state_r <= SWBE_Q2;
        SWBE_Q2:   state_r <= SWBE_Q3;
        SWBE_Q3:   state_r <= SWBE_Q4;
        SWBE_Q4:   state_r <= (take && is_match) ? SWBE_Q1 : SWBE_IDLE;
        default:   state_r <= SWBE_IDLE;
      endcase
    end
  end

  // decode latch: the word is sampled once, at the hand-off into the first quarter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= 12'h000;
      dest_r <= 1'b0;
    end else if (take && is_match) begin
      dest_r <= instr_word[`SWBE_DEST_BIT];
      addr_r <= resolve_addr(instr_word[7:0], instr_word[`SWBE_BANK_BIT],
                             bank_select_reg_r, ext_en_r, idx_base_r);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_done   <= 1'b0;
      instr_reject <= 1'b0;
    end else begin
      instr_done   <= (state_r == SWBE_Q4);
      instr_reject <= take && !is_match;
    end
  end

  // ----------------------------------------
  // datapath quarters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (state_r == SWBE_Q2) begin
      operand_r <= general_purpose_ram[addr_r];
    end
  end

  assign alu_bus.acc_val  = acc_r;
  assign alu_bus.file_val = operand_r;
  assign alu_bus.carry_in = status_r[`SWBE_ST_C];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_r   <= 8'h00;
      flags_r <= 5'h00;
    end else if (state_r == SWBE_Q3) begin
      res_r   <= alu_bus.diff;
      flags_r <= alu_bus.flags;
    end
  end

  // ----------------------------------------
  // accumulator and status; the write quarter wins over a software write
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= `SWBE_RST_ACC;
    end else if (state_r == SWBE_Q4 && !dest_r) begin
      acc_r <= res_r;
    end else if (reg_wr && reg_addr == `SWBE_OFS_ACC) begin
      acc_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= `SWBE_RST_STATUS;
    end else if (state_r == SWBE_Q4) begin
      status_r <= flags_r;
    end else if (reg_wr && reg_addr == `SWBE_OFS_STATUS) begin
      status_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_select_reg_r <= `SWBE_RST_BANK;
      ext_en_r          <= 1'b0;
      idx_base_r        <= `SWBE_RST_IDX;
      ptr_r             <= 12'h000;
    end else if (reg_wr) begin
      case (reg_addr)
        `SWBE_OFS_BANK:   bank_select_reg_r <= reg_wdata[3:0];
        `SWBE_OFS_CTRL:   ext_en_r          <= reg_wdata[`SWBE_CTRL_EXT];
        `SWBE_OFS_IDX_LO: idx_base_r[7:0]   <= reg_wdata;
        `SWBE_OFS_IDX_HI: idx_base_r[11:8]  <= reg_wdata[3:0];
        `SWBE_OFS_PTR_LO: ptr_r[7:0]        <= reg_wdata;
        `SWBE_OFS_PTR_HI: ptr_r[11:8]       <= reg_wdata[3:0];
        default:          ptr_r             <= ptr_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 8'h00;
    end else if (state_r == SWBE_Q4) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ----------------------------------------
  // data memory: one write port, the instruction has priority
  // ----------------------------------------
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = ptr_r;
    mem_wdata = reg_wdata;
    if (state_r == SWBE_Q4 && dest_r) begin
      mem_we    = 1'b1;
      mem_waddr = addr_r;
      mem_wdata = res_r;
    end else if (reg_wr && reg_addr == `SWBE_OFS_MEM) begin
      mem_we    = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      general_purpose_ram[mem_waddr] <= mem_wdata;
    end
  end

  // ----------------------------------------
  // read port: data one cycle after the strobe, unmapped reads zero
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SWBE_OFS_ACC:    reg_rdata <= acc_r;
        `SWBE_OFS_STATUS: reg_rdata <= {3'h0, status_r};
        `SWBE_OFS_BANK:   reg_rdata <= {4'h0, bank_select_reg_r};
        `SWBE_OFS_CTRL:   reg_rdata <= {7'h00, ext_en_r};
        `SWBE_OFS_IDX_LO: reg_rdata <= idx_base_r[7:0];
        `SWBE_OFS_IDX_HI: reg_rdata <= {4'h0, idx_base_r[11:8]};
        `SWBE_OFS_PTR_LO: reg_rdata <= ptr_r[7:0];
        `SWBE_OFS_PTR_HI: reg_rdata <= {4'h0, ptr_r[11:8]};
        `SWBE_OFS_MEM:    reg_rdata <= general_purpose_ram[ptr_r];
        `SWBE_OFS_COUNT:  reg_rdata <= count_r;
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_quarter_walk:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SWBE_Q1 |=> state_r == SWBE_Q2 ##1 state_r == SWBE_Q3 ##1 state_r == SWBE_Q4)
    else $error("quarters did not run in order");

  a_decode_match:
  assert property (@(posedge clk) disable iff (!rst_b)
    take |=> (state_r == SWBE_Q1) == $past(instr_word[15:10] == 6'b010101))
    else $error("decode of opcode field wrong");

  a_dest_acc:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SWBE_Q4 && !dest_r |->
      mem_we == (reg_wr && reg_addr == `SWBE_OFS_MEM) ##1 acc_r == $past(res_r))
    else $error("accumulator destination mishandled");

  a_dest_file:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SWBE_Q4 && dest_r |-> mem_we && mem_waddr == addr_r && mem_wdata == res_r)
    else $error("file destination not written");

  a_bank_access:
  assert property (@(posedge clk) disable iff (!rst_b)
    take && is_match && !instr_word[8] && !ext_en_r |=>
      addr_r == ($past(instr_word[7]) || $past(instr_word[6:5]) == 2'b11 ?
                 {4'hF, $past(instr_word[7:0])} : {4'h0, $past(instr_word[7:0])}))
    else $error("access bank address wrong");

  a_bank_select:
  assert property (@(posedge clk) disable iff (!rst_b)
    take && is_match && instr_word[8] |=>
      addr_r == {$past(bank_select_reg_r), $past(instr_word[7:0])})
    else $error("banked address wrong");

  a_indexed_mode:
  assert property (@(posedge clk) disable iff (!rst_b)
    take && is_match && !instr_word[8] && ext_en_r && instr_word[7:0] < 8'h60 |=>
      addr_r == $past(idx_base_r) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed literal offset wrong");

  a_sub_value:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SWBE_Q3 |=>
      res_r == 8'($past(acc_r) - $past(operand_r) - {7'h00, !$past(status_r[0])}))
    else $error("difference wrong");

  a_flag_carry:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == SWBE_Q3 ##1 1'b1 ##1 1'b1 |->
      status_r[0] == ({1'b0, $past(acc_r, 2)} >=
                      {1'b0, $past(operand_r, 2)} + {8'h00, !$past(status_r[0], 2)})
      && status_r[2] == ($past(res_r) == 8'h00) && status_r[4] == $past(res_r[7]))
    else $error("status flags wrong");
endmodule

// file: design/swbe_defines.svh
// offsets, field positions, reset values and opcode fields of the subtract-with-borrow core
`ifndef SWBE_DEFINES_SVH
`define SWBE_DEFINES_SVH

// ----------------------------------------
// software register offsets (4-bit address)
// ----------------------------------------
`define SWBE_OFS_ACC      4'h0
`define SWBE_OFS_STATUS   4'h1
`define SWBE_OFS_BANK     4'h2
`define SWBE_OFS_CTRL     4'h3
`define SWBE_OFS_IDX_LO   4'h4
`define SWBE_OFS_IDX_HI   4'h5
`define SWBE_OFS_PTR_LO   4'h6
`define SWBE_OFS_PTR_HI   4'h7
`define SWBE_OFS_MEM      4'h8
`define SWBE_OFS_COUNT    4'h9

// ----------------------------------------
// status and control bit positions
// ----------------------------------------
`define SWBE_ST_C         0
`define SWBE_ST_HALF      1
`define SWBE_ST_Z         2
`define SWBE_ST_SOVF      3
`define SWBE_ST_N         4
`define SWBE_CTRL_EXT     0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SWBE_RST_ACC      8'h00
`define SWBE_RST_STATUS   5'h00
`define SWBE_RST_BANK     4'h0
`define SWBE_RST_IDX      12'h000

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define SWBE_OPCODE       6'h15
`define SWBE_OP_HI        15
`define SWBE_OP_LO        10
`define SWBE_DEST_BIT     9
`define SWBE_BANK_BIT     8
`define SWBE_IDX_LIMIT    8'h5F
`define SWBE_ACCESS_HI    4'hF
`define SWBE_QUARTERS     4

`endif

// file: design/swbe_pkg.sv
// types shared by the subtract-with-borrow core
package swbe_pkg;
  typedef enum logic [4:0] {
    SWBE_IDLE = 5'b00001,
    SWBE_Q1   = 5'b00010,
    SWBE_Q2   = 5'b00100,
    SWBE_Q3   = 5'b01000,
    SWBE_Q4   = 5'b10000
  } swbe_state_t;
endpackage

// file: design/swbe_alu_if.sv
// operand and result bundle between the core sequencer and its arithmetic unit
`timescale 1ns/1ps
interface swbe_alu_if;
  logic [7:0] acc_val;
  logic [7:0] file_val;
  logic       carry_in;
  logic [7:0] diff;
  logic [4:0] flags;
  modport core (output acc_val, output file_val, output carry_in, input diff, input flags);
  modport alu  (input acc_val, input file_val, input carry_in, output diff, output flags);
endinterface

// file: design/swbe_alu.sv
// subtract with borrow: acc - file - !carry, with status flags
`timescale 1ns/1ps
`include "swbe_defines.svh"
module swbe_alu
  import swbe_pkg::*;
(
  swbe_alu_if.alu p
);
  logic [8:0] wide;
  logic [4:0] nib;

  // carry is an inverted borrow: a clear carry takes one more away
  always_comb begin
    wide = {1'b0, p.acc_val} - {1'b0, p.file_val} - {8'h00, ~p.carry_in};
    nib  = {1'b0, p.acc_val[3:0]} - {1'b0, p.file_val[3:0]} - {4'h0, ~p.carry_in};
  end

  assign p.diff = wide[7:0];
  always_comb begin
    p.flags                = 5'h00;
    p.flags[`SWBE_ST_C]    = ~wide[8];
    p.flags[`SWBE_ST_HALF] = ~nib[4];
    p.flags[`SWBE_ST_Z]    = (wide[7:0] == 8'h00);
    p.flags[`SWBE_ST_N]    = wide[7];
    p.flags[`SWBE_ST_SOVF] = (p.acc_val[7] ^ p.file_val[7]) & (p.acc_val[7] ^ wide[7]);
  end
endmodule

// file: sim/tb_top.sv
// self-checking testbench of the subtract-with-borrow core
`timescale 1ns/1ps
`include "swbe_defines.svh"
module tb_top
  import swbe_pkg::*;
();
  logic        clk;
  logic        rst_b;
  logic [15:0] instr_word;
  logic        instr_valid;
  logic        instr_ready;
  logic        instr_done;
  logic        instr_reject;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  int          fails;
  int          cmp_count;
  int          cycles;
  logic [31:0] seed;
  logic [7:0]  rv;
  logic [7:0]  ca [0:6] = '{8'h02, 8'h05, 8'h02, 8'h80, 8'h00, 8'h7F, 8'h10};
  logic [7:0]  cf [0:6] = '{8'h03, 8'h02, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'h01};
  logic [7:0]  cx [0:6] = '{8'h00, 8'h5F, 8'h60, 8'hFF, 8'h5F, 8'h10, 8'h5F};
  logic [6:0]  cc = 7'b1001011;
  logic [6:0]  cd = 7'b0100101;
  logic [3:0]  ro [0:5] = '{`SWBE_OFS_ACC, `SWBE_OFS_STATUS, `SWBE_OFS_BANK, `SWBE_OFS_CTRL,
                            `SWBE_OFS_COUNT, 4'hA};

  swbe_core dut (.clk(clk), .rst_b(rst_b), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_done(instr_done), .instr_reject(instr_reject),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ----------------------------------------
  // reference functions
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [4:0] exp_flags(input logic [7:0] a, input logic [7:0] f,
                                           input logic c);
    logic [8:0] w;
    logic [4:0] l;
    logic [4:0] g;
    w = {1'b0, a} - {1'b0, f} - {8'h00, ~c};
    l = {1'b0, a[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
    g = 5'h00;
    g[`SWBE_ST_C] = ~w[8];
    g[`SWBE_ST_HALF] = ~l[4];
    g[`SWBE_ST_Z] = (w[7:0] == 8'h00);
    g[`SWBE_ST_SOVF] = (a[7] != f[7]) && (w[7] != a[7]);
    g[`SWBE_ST_N] = w[7];
    return g;
  endfunction

  function automatic logic [11:0] exp_addr(input logic ab, input logic [3:0] bk,
                                           input logic ext, input logic [11:0] idx,
                                           input logic [7:0] f);
    if (ab) return {bk, f};
    if (ext && f <= 8'h5F) return idx + {4'h0, f};
    return (f <= 8'h5F) ? {4'h0, f} : {4'hF, f};
  endfunction

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic issue(input logic [15:0] w);
    @(posedge clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic run_sub(input logic [7:0] av, input logic [7:0] fv, input logic c,
                         input logic d, input logic ab, input logic [7:0] f,
                         input logic [3:0] bk, input logic ext, input logic [11:0] idx);
    logic [11:0] ad;
    logic [7:0]  df;
    int          n;
    ad = exp_addr(ab, bk, ext, idx, f);
    df = av - fv - {7'h00, ~c};
    wr(`SWBE_OFS_BANK, {4'h0, bk});
    wr(`SWBE_OFS_CTRL, {7'h00, ext});
    wr(`SWBE_OFS_IDX_LO, idx[7:0]);
    wr(`SWBE_OFS_IDX_HI, {4'h0, idx[11:8]});
    wr(`SWBE_OFS_PTR_LO, ad[7:0]);
    wr(`SWBE_OFS_PTR_HI, {4'h0, ad[11:8]});
    wr(`SWBE_OFS_MEM, fv);
    wr(`SWBE_OFS_ACC, av);
    // stale ones in the other flags show a flag that never updates
    wr(`SWBE_OFS_STATUS, {7'h0F, c});
    issue({`SWBE_OPCODE, d, ab, f});
    chk("instr_ready in Q1", 12'h000, {11'h000, instr_ready});
    chk("instr_reject", 12'h000, {11'h000, instr_reject});
    n = 0;
    while (instr_done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    chk("done latency", 12'h004, n[11:0]);
    rd(`SWBE_OFS_ACC, rv);
    chk("acc", {4'h0, d ? av : df}, {4'h0, rv});
    rd(`SWBE_OFS_STATUS, rv);
    chk("status", {7'h00, exp_flags(av, fv, c)}, {4'h0, rv});
    rd(`SWBE_OFS_MEM, rv);
    chk("file reg", {4'h0, d ? df : fv}, {4'h0, rv});
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    seed = 32'd45009;
    rst_b = 1'b0;
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ro[i], rv);
      chk("reset value", 12'h000, {4'h0, rv});
    end
    $display("test reset values done");
    // borrow, zero, overflow and nibble edges with access-bank boundary addresses
    for (int i = 0; i < 7; i++) begin
      run_sub(ca[i], cf[i], cc[i], cd[i], i[0], cx[i], 4'hA, i[1], 12'hFC0);
    end
    $display("test corner cases done");
    for (int i = 0; i < 40; i++) begin
      logic [31:0] r;
      r = rnd();
      run_sub(r[7:0], r[15:8], r[16], r[17], r[18], r[26:19], r[30:27], r[31],
              rnd() & 32'hFFF);
    end
    $display("test random operands done");
    wr(`SWBE_OFS_ACC, 8'h55);
    for (int i = 0; i < 6; i++) begin
      int seen;
      // destination bit 0, so a wrongly run word would disturb the accumulator
      issue({`SWBE_OPCODE ^ (6'h01 << i), 2'b00, 8'h12});
      chk("instr_reject", 12'h001, {11'h000, instr_reject});
      seen = 0;
      repeat (6) begin
        @(posedge clk);
        #1 seen += instr_done;
      end
      chk("done after reject", 12'h000, seen[11:0]);
    end
    rd(`SWBE_OFS_ACC, rv);
    chk("acc after reject", 12'h055, {4'h0, rv});
    $display("test rejected words done");
    // a word offered in the write quarter is taken at once, with no idle cycle
    wr(`SWBE_OFS_BANK, 8'h02);
    wr(`SWBE_OFS_PTR_LO, 8'h40);
    wr(`SWBE_OFS_PTR_HI, 8'h02);
    wr(`SWBE_OFS_MEM, 8'h03);
    wr(`SWBE_OFS_ACC, 8'h10);
    wr(`SWBE_OFS_STATUS, 8'h00);
    issue({`SWBE_OPCODE, 2'b01, 8'h40});
    repeat (3) @(posedge clk);
    instr_word <= {`SWBE_OPCODE, 2'b01, 8'h40};
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 chk("done of first word", 12'h001, {11'h000, instr_done});
    repeat (4) @(posedge clk);
    #1 chk("done of second word", 12'h001, {11'h000, instr_done});
    rd(`SWBE_OFS_ACC, rv);
    chk("acc 2 words", {4'h0, 8'h10 - 8'h03 - 8'h01 - 8'h03}, {4'h0, rv});
    rd(`SWBE_OFS_STATUS, rv);
    chk("status 2 words", {7'h00, exp_flags(8'h0C, 8'h03, 1'b1)}, {4'h0, rv});
    $display("test back-to-back words done");
    final_report();
  end
endmodule
